// File: inc/msc_pkg.sv
package msc_pkg;

  localparam int MSC_ADDR_W = 3;
  localparam int MSC_DATA_W = 8;
  localparam int MSC_LINES = 4;
  localparam int MSC_EV_W = 2;

  // Register word offsets on the plain register port.
  localparam logic [MSC_ADDR_W-1:0] MSC_OFF_LINE_STATE = 3'h0;
  localparam logic [MSC_ADDR_W-1:0] MSC_OFF_SCRATCH = 3'h1;
  localparam logic [MSC_ADDR_W-1:0] MSC_OFF_OUT_CTRL = 3'h2;
  localparam logic [MSC_ADDR_W-1:0] MSC_OFF_FEATURE = 3'h3;
  localparam logic [MSC_ADDR_W-1:0] MSC_OFF_IRQ_STATUS = 3'h4;
  localparam logic [MSC_ADDR_W-1:0] MSC_OFF_IRQ_CLEAR = 3'h5;
  localparam logic [MSC_ADDR_W-1:0] MSC_OFF_IRQ_ENABLE = 3'h6;

  // Line index: delta flags sit at these bits, levels at these plus four.
  localparam int MSC_LN_CTS = 0;
  localparam int MSC_LN_DSR = 1;
  localparam int MSC_LN_RI = 2;
  localparam int MSC_LN_CD = 3;
  localparam int MSC_LVL_LSB = 4;

  // modem_output_control fields.
  localparam int MSC_OC_DTR = 0;
  localparam int MSC_OC_RTS = 1;
  localparam int MSC_OC_USER_ONE = 2;
  localparam int MSC_OC_USER_TWO = 3;
  localparam int MSC_OC_LOOP = 4;
  localparam int MSC_OC_W = 5;

  // enhanced_feature_control field.
  localparam int MSC_FC_AUTO_CTS = 7;

  // Interrupt status bits.
  localparam int MSC_EV_MODEM = 0;
  localparam int MSC_EV_TX_HALT = 1;

  localparam logic [MSC_DATA_W-1:0] MSC_BYTE_RST = 8'h00;
  localparam logic [MSC_OC_W-1:0] MSC_OC_RST = 5'h00;
  localparam logic [MSC_LINES-1:0] MSC_PIN_IDLE = 4'hf;
  localparam logic [MSC_LINES-1:0] MSC_LINES_ZERO = 4'h0;
  localparam logic [MSC_EV_W-1:0] MSC_EV_ZERO = 2'h0;
  localparam logic [1:0] MSC_PRIME_DONE = 2'h3;
  localparam logic [1:0] MSC_PRIME_RST = 2'h0;
  localparam logic [1:0] MSC_PRIME_STEP = 2'h1;

  typedef struct packed {
    logic [MSC_ADDR_W-1:0] addr;
    logic [MSC_DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } msc_bus_req_t;

  // Modem control pins, active low as on the connector.
  typedef struct packed {
    logic cd_n;
    logic ri_n;
    logic dsr_n;
    logic cts_n;
  } msc_modem_in_t;

  typedef enum logic [0:0] {
    MSC_TX_RUN,
    MSC_TX_HELD
  } msc_tx_state_t;

endpackage : msc_pkg

// File: logic/msc_top.sv
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
// Overview of operation
// - Each of four change flags becomes 1 when its modem input changes, the ring flag on a rise only.
// - A read of modem_line_state clears each change flag that no new change sets in that same cycle.
// - Normally bit 7 reads the inverted carrier detect pin.
// - In loop-back bit 7 reads user_output_two from modem_output_control.
// - Bit 6 reads inverted ring pin, or user_output_one in loop-back.
// - Bit 5 reads inverted DSR pin, or DTR control bit in loop-back.
// - Bit 4 reads inverted CTS pin, or RTS control bit in loop-back.
// - With auto CTS on, high CTS stops transmit after current character.
// - Bits 3, 1, 0 flag any change of CD, DSR, CTS since last read.
// - Bit 2 sets only on ring pin rising from low to high.
// - Modem status interrupt is high while any change flag is set.
// - scratch_byte holds the last written byte and steers nothing.
// - Halted transmit resumes when CTS returns low; auto CTS resets off.
module msc_top
  import msc_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire msc_bus_req_t bus_req,
  output logic [MSC_DATA_W-1:0] rd_data,
  input wire msc_modem_in_t modem_pins,
  input wire logic tx_char_busy,
  output logic tx_allow,
  output logic dtr_n,
  output logic rts_n,
  output logic user_one_n,
  output logic user_two_n,
  output logic modem_irq,
  output logic irq
);

  logic [MSC_LINES-1:0] pin_meta_r;
  logic [MSC_LINES-1:0] pin_sync_r;
  logic [MSC_LINES-1:0] level;
  logic [MSC_LINES-1:0] level_prev_r;
  logic [1:0] prime_r;
  logic primed;
  logic [MSC_LINES-1:0] change_evt;
  logic [MSC_LINES-1:0] delta_r;
  logic [MSC_LINES-1:0] delta_nxt;
  logic line_rd;
  logic [MSC_DATA_W-1:0] scratch_r;
  logic [MSC_OC_W-1:0] out_ctrl_r;
  logic [MSC_DATA_W-1:0] feature_r;
  logic [MSC_EV_W-1:0] irq_sts_r;
  logic [MSC_EV_W-1:0] irq_sts_nxt;
  logic [MSC_EV_W-1:0] irq_en_r;
  logic [MSC_EV_W-1:0] irq_evt;
  logic loop_on;
  logic auto_cts;
  logic cts_pin_high;
  msc_tx_state_t tx_state_r;
  msc_tx_state_t tx_state_nxt;
  logic [MSC_DATA_W-1:0] rd_data_r;
  logic [MSC_DATA_W-1:0] rd_data_nxt;
  logic modem_irq_r;
  logic irq_r;
  logic tx_allow_r;

  // Pins are asynchronous to mclk; two stages before anything reads them.
  always_ff @(posedge mclk) begin
    if (reset) begin
      pin_meta_r <= MSC_PIN_IDLE;
      pin_sync_r <= MSC_PIN_IDLE;
    end else begin
      pin_meta_r <= modem_pins;
      pin_sync_r <= pin_meta_r;
    end
  end

  assign loop_on = out_ctrl_r[MSC_OC_LOOP];
  assign auto_cts = feature_r[MSC_FC_AUTO_CTS];

  // Active-high line levels as reported in the upper nibble of the status byte.
  always_comb begin
    if (loop_on) begin
      level[MSC_LN_CD] = out_ctrl_r[MSC_OC_USER_TWO];
      level[MSC_LN_RI] = out_ctrl_r[MSC_OC_USER_ONE];
      level[MSC_LN_DSR] = out_ctrl_r[MSC_OC_DTR];
      level[MSC_LN_CTS] = out_ctrl_r[MSC_OC_RTS];
    end else begin
      level[MSC_LN_CD] = ~pin_sync_r[MSC_LN_CD];
      level[MSC_LN_RI] = ~pin_sync_r[MSC_LN_RI];
      level[MSC_LN_DSR] = ~pin_sync_r[MSC_LN_DSR];
      level[MSC_LN_CTS] = ~pin_sync_r[MSC_LN_CTS];
    end
  end

  // Edge detection waits until the synchroniser holds real pin values.
  always_ff @(posedge mclk) begin
    if (reset) begin
      prime_r <= MSC_PRIME_RST;
      level_prev_r <= MSC_LINES_ZERO;
    end else begin
      if (prime_r != MSC_PRIME_DONE) begin
        prime_r <= prime_r + MSC_PRIME_STEP;
      end
      level_prev_r <= level;
    end
  end

  assign primed = (prime_r == MSC_PRIME_DONE);
  assign line_rd = bus_req.rd && (bus_req.addr == MSC_OFF_LINE_STATE);

  genvar gi;
  generate
    for (gi = 0; gi < MSC_LINES; gi++) begin : g_line
      if (gi == MSC_LN_RI) begin : g_ring
        // Ring pin low to high is the level falling from one to zero.
        assign change_evt[gi] = primed && level_prev_r[gi] && !level[gi];
      end else begin : g_any
        assign change_evt[gi] = primed && (level_prev_r[gi] != level[gi]);
      end
      // The set term wins over the clear from a read in the same cycle.
      assign delta_nxt[gi] = change_evt[gi] || (delta_r[gi] && !line_rd);
    end
  endgenerate

  always_ff @(posedge mclk) begin
    if (reset) begin
      delta_r <= MSC_LINES_ZERO;
      modem_irq_r <= 1'b0;
    end else begin
      delta_r <= delta_nxt;
      modem_irq_r <= |delta_nxt;
    end
  end

  // Software-written registers.
  always_ff @(posedge mclk) begin
    if (reset) begin
      scratch_r <= MSC_BYTE_RST;
      out_ctrl_r <= MSC_OC_RST;
      feature_r <= MSC_BYTE_RST;
      irq_en_r <= MSC_EV_ZERO;
    end else if (bus_req.wr) begin
      case (bus_req.addr)
        MSC_OFF_SCRATCH: scratch_r <= bus_req.wdata;
        MSC_OFF_OUT_CTRL: out_ctrl_r <= bus_req.wdata[MSC_OC_W-1:0];
        MSC_OFF_FEATURE: feature_r <= bus_req.wdata;
        MSC_OFF_IRQ_ENABLE: irq_en_r <= bus_req.wdata[MSC_EV_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Modem control outputs; in loop-back they park inactive (high).
  always_ff @(posedge mclk) begin
    if (reset) begin
      dtr_n <= 1'b1;
      rts_n <= 1'b1;
      user_one_n <= 1'b1;
      user_two_n <= 1'b1;
    end else begin
      dtr_n <= loop_on || !out_ctrl_r[MSC_OC_DTR];
      rts_n <= loop_on || !out_ctrl_r[MSC_OC_RTS];
      user_one_n <= loop_on || !out_ctrl_r[MSC_OC_USER_ONE];
      user_two_n <= loop_on || !out_ctrl_r[MSC_OC_USER_TWO];
    end
  end

  // Transmit gate: a halt is taken only between characters; a resume is taken at once.
  assign cts_pin_high = !level[MSC_LN_CTS];

  always_comb begin
    tx_state_nxt = tx_state_r;
    case (tx_state_r)
      MSC_TX_RUN: begin
        if (!tx_char_busy && auto_cts && cts_pin_high) begin
          tx_state_nxt = MSC_TX_HELD;
        end
      end
      MSC_TX_HELD: begin
        if (!auto_cts || !cts_pin_high) begin
          tx_state_nxt = MSC_TX_RUN;
        end
      end
      default: tx_state_nxt = MSC_TX_RUN;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      tx_state_r <= MSC_TX_RUN;
      tx_allow_r <= 1'b1;
    end else begin
      tx_state_r <= tx_state_nxt;
      tx_allow_r <= (tx_state_nxt == MSC_TX_RUN);
    end
  end

  // Sticky interrupt status; a new event wins over a clear in the same cycle.
  assign irq_evt[MSC_EV_MODEM] = |change_evt;
  assign irq_evt[MSC_EV_TX_HALT] = (tx_state_r == MSC_TX_RUN) && (tx_state_nxt == MSC_TX_HELD);

  always_comb begin
    irq_sts_nxt = irq_sts_r;
    if (bus_req.wr && (bus_req.addr == MSC_OFF_IRQ_CLEAR)) begin
      irq_sts_nxt = irq_sts_r & ~bus_req.wdata[MSC_EV_W-1:0];
    end
    irq_sts_nxt = irq_sts_nxt | irq_evt;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_sts_r <= MSC_EV_ZERO;
      irq_r <= 1'b0;
    end else begin
      irq_sts_r <= irq_sts_nxt;
      irq_r <= |(irq_sts_nxt & irq_en_r);
    end
  end

  // Read data stand in the cycle after the strobe and are zero otherwise.
  always_comb begin
    rd_data_nxt = MSC_BYTE_RST;
    if (bus_req.rd) begin
      case (bus_req.addr)
        MSC_OFF_LINE_STATE: rd_data_nxt = {level, delta_r};
        MSC_OFF_SCRATCH: rd_data_nxt = scratch_r;
        MSC_OFF_OUT_CTRL: rd_data_nxt[MSC_OC_W-1:0] = out_ctrl_r;
        MSC_OFF_FEATURE: rd_data_nxt = feature_r;
        MSC_OFF_IRQ_STATUS: rd_data_nxt[MSC_EV_W-1:0] = irq_sts_r;
        MSC_OFF_IRQ_ENABLE: rd_data_nxt[MSC_EV_W-1:0] = irq_en_r;
        default: rd_data_nxt = MSC_BYTE_RST;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rd_data_r <= MSC_BYTE_RST;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  assign rd_data = rd_data_r;
  assign modem_irq = modem_irq_r;
  assign irq = irq_r;
  assign tx_allow = tx_allow_r;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  sequence s_line_read;
    bus_req.rd && (bus_req.addr == MSC_OFF_LINE_STATE);
  endsequence

  sequence s_scratch_write;
    bus_req.wr && (bus_req.addr == MSC_OFF_SCRATCH);
  endsequence

  sequence s_scratch_read;
    bus_req.rd && (bus_req.addr == MSC_OFF_SCRATCH);
  endsequence

  sequence s_halt_cond;
    !tx_char_busy && auto_cts && cts_pin_high;
  endsequence

  a_cts_delta_set: assert property (primed && (level[MSC_LN_CTS] != level_prev_r[MSC_LN_CTS])
    |=> delta_r[MSC_LN_CTS]) else $error("cts change flag not set");

  a_cd_delta_set: assert property (primed && (level[MSC_LN_CD] != level_prev_r[MSC_LN_CD])
    |=> delta_r[MSC_LN_CD]) else $error("cd change flag not set");

  a_read_clears_flags: assert property (s_line_read ##0 (change_evt == MSC_LINES_ZERO)
    |=> (delta_r == MSC_LINES_ZERO) && !modem_irq_r) else $error("read did not clear flags");

  a_set_beats_read: assert property (s_line_read ##0 (change_evt != MSC_LINES_ZERO)
    |=> ((delta_r & $past(change_evt)) == $past(change_evt))) else $error("change lost under read");

  a_ri_falling_ignored: assert property (!delta_r[MSC_LN_RI] && !level_prev_r[MSC_LN_RI]
    && level[MSC_LN_RI] |=> !delta_r[MSC_LN_RI]) else $error("ring flag set on wrong edge");

  a_flag_holds_unread: assert property (delta_r[MSC_LN_CD] && !line_rd
    |=> delta_r[MSC_LN_CD]) else $error("change flag dropped without read");

  a_cd_normal_read: assert property (s_line_read ##0 !loop_on
    |=> rd_data_r[MSC_LVL_LSB + MSC_LN_CD] == !$past(pin_sync_r[MSC_LN_CD]))
    else $error("cd level wrong");

  a_loop_read_map: assert property (s_line_read ##0 loop_on
    |=> rd_data_r[MSC_DATA_W-1:MSC_LVL_LSB] == {$past(out_ctrl_r[MSC_OC_USER_TWO]),
      $past(out_ctrl_r[MSC_OC_USER_ONE]), $past(out_ctrl_r[MSC_OC_DTR]), $past(out_ctrl_r[MSC_OC_RTS])})
    else $error("loop-back levels wrong");

  a_modem_irq_level: assert property ((delta_r != MSC_LINES_ZERO) |-> modem_irq_r)
    else $error("modem interrupt missing");

  a_scratch_returns: assert property (s_scratch_write ##1 !bus_req.wr ##1 s_scratch_read
    |=> rd_data_r == $past(bus_req.wdata, 3)) else $error("scratch byte not kept");

  a_cts_halts_tx: assert property (s_halt_cond |=> !tx_allow_r)
    else $error("transmit not halted");

  a_busy_holds_gate: assert property (tx_allow_r && tx_char_busy |=> tx_allow_r)
    else $error("gate dropped mid character");

  a_cts_resumes_tx: assert property (!tx_allow_r && !cts_pin_high |=> tx_allow_r)
    else $error("transmit not resumed");

endmodule : msc_top

// File: dv/msc_modem_model.sv
`timescale 1ns/1ps
// Modem side: shows the requested pin levels one clock later, or four clocks later when slow is high.
module msc_modem_model
  import msc_pkg::*;
(
  input wire logic mclk,
  input wire msc_modem_in_t want,
  input wire logic slow,
  output msc_modem_in_t modem_pins
);
  msc_modem_in_t d1_r, d2_r, d3_r;
  initial modem_pins = MSC_PIN_IDLE;
  always @(posedge mclk) begin
    d1_r <= want;
    d2_r <= d1_r;
    d3_r <= d2_r;
    modem_pins <= slow ? d3_r : want;
  end
endmodule : msc_modem_model

// File: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import msc_pkg::*;
;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  msc_bus_req_t bus_req = '0;
  logic [7:0] rd_data;
  logic [3:0] want = MSC_PIN_IDLE;
  msc_modem_in_t modem_pins;
  logic slow = 1'b0;
  logic tx_char_busy = 1'b0;
  logic tx_allow, dtr_n, rts_n, user_one_n, user_two_n, modem_irq, irq;
  logic rd_q = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] rnd;
  int fail_count = 0;
  int cmp_count = 0;

  always #12.5 mclk = ~mclk;

  msc_top dut(.mclk(mclk), .reset(reset), .bus_req(bus_req), .rd_data(rd_data), .modem_pins(modem_pins),
    .tx_char_busy(tx_char_busy), .tx_allow(tx_allow), .dtr_n(dtr_n), .rts_n(rts_n),
    .user_one_n(user_one_n), .user_two_n(user_two_n), .modem_irq(modem_irq), .irq(irq));
  msc_modem_model modem(.mclk(mclk), .want(want), .slow(slow), .modem_pins(modem_pins));

  task automatic compare(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : compare

  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report

  // Read data stand only in the cycle after the strobe, so compare then.
  always @(posedge mclk) begin
    if (rd_q) compare(rd_data, exp_q.pop_front());
    rd_q <= bus_req.rd;
  end

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge mclk);
    exp_q.push_back(e);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
  endtask : rd

  // Ends at a falling edge so that outputs sampled afterwards are settled.
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask : idle

  task automatic wait_allow(input logic e);
    int k;
    for (k = 0; k < 10 && tx_allow !== e; k++) @(negedge mclk);
    if (tx_allow !== e) begin
      fail_count++;
      final_report();
    end
  endtask : wait_allow

  // Expected status byte: levels above, change flags below; ring flags only on a falling level.
  function automatic logic [7:0] st(input logic [3:0] p, input logic [3:0] n);
    logic [3:0] f;
    f = p ^ n;
    f[MSC_LN_RI] = p[MSC_LN_RI] & ~n[MSC_LN_RI];
    return {n, f};
  endfunction : st

  initial begin
    logic [3:0] p;
    logic [3:0] n;
    int i;
    p = 4'h0;
    void'($urandom(32'h2cad_23f8));
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    idle(4);
    compare({1'b0, tx_allow, dtr_n, rts_n, user_one_n, user_two_n, modem_irq, irq}, 8'h7c);
    for (i = 0; i < 8; i++) if (i != 5) rd(i[2:0], 8'h00);
    rnd = 8'($urandom());
    wr(MSC_OFF_SCRATCH, rnd);
    wr(MSC_OFF_LINE_STATE, ~rnd);
    wr(3'h7, ~rnd);
    rd(MSC_OFF_SCRATCH, rnd);
    rd(MSC_OFF_LINE_STATE, 8'h00);
    for (i = 0; i < MSC_LINES; i++) begin
      slow <= i[0];
      want[i] <= 1'b0;
      idle(8);
      compare({7'h00, modem_irq}, {7'h00, (i != MSC_LN_RI)});
      n = ~want;
      rd(MSC_OFF_LINE_STATE, st(p, n));
      rd(MSC_OFF_LINE_STATE, {n, 4'h0});
      idle(0);
      compare({7'h00, modem_irq}, 8'h00);
      p = n;
      want[i] <= 1'b1;
      idle(8);
      n = ~want;
      compare({7'h00, modem_irq}, 8'h01);
      rd(MSC_OFF_LINE_STATE, st(p, n));
      p = n;
    end
    slow <= 1'b0;
    want[MSC_LN_CTS] <= 1'b0;
    idle(2);
    rd(MSC_OFF_LINE_STATE, 8'h10);
    rd(MSC_OFF_LINE_STATE, 8'h11);
    want[MSC_LN_CTS] <= 1'b1;
    idle(3);
    want[MSC_LN_CTS] <= 1'b0;
    idle(8);
    rd(MSC_OFF_LINE_STATE, 8'h11);
    p = 4'h1;
    for (i = 0; i < 16; i++) begin
      if (i > 0) want <= 4'($urandom());
      wr(MSC_OFF_OUT_CTRL, 8'h10 | 8'(i));
      idle(6);
      n = {i[3], i[2], i[0], i[1]};
      rd(MSC_OFF_LINE_STATE, st(p, n));
      p = n;
    end
    compare({4'h0, dtr_n, rts_n, user_one_n, user_two_n}, 8'h0f);
    want <= MSC_PIN_IDLE;
    idle(4);
    wr(MSC_OFF_OUT_CTRL, 8'h0f);
    idle(8);
    compare({4'h0, dtr_n, rts_n, user_one_n, user_two_n}, 8'h00);
    rd(MSC_OFF_LINE_STATE, st(p, 4'h0));
    wr(MSC_OFF_IRQ_CLEAR, 8'h03);
    tx_char_busy <= 1'b1;
    wr(MSC_OFF_FEATURE, 8'h80);
    idle(4);
    compare({7'h00, tx_allow}, 8'h01);
    tx_char_busy <= 1'b0;
    idle(3);
    compare({7'h00, tx_allow}, 8'h00);
    rd(MSC_OFF_IRQ_STATUS, 8'h02);
    wr(MSC_OFF_IRQ_ENABLE, 8'h02);
    idle(2);
    compare({7'h00, irq}, 8'h01);
    wr(MSC_OFF_IRQ_ENABLE, 8'h01);
    idle(2);
    compare({7'h00, irq}, 8'h00);
    wr(MSC_OFF_IRQ_CLEAR, 8'h02);
    rd(MSC_OFF_IRQ_STATUS, 8'h00);
    want[MSC_LN_CTS] <= 1'b0;
    wait_allow(1'b1);
    idle(2);
    compare({7'h00, irq}, 8'h01);
    rd(MSC_OFF_LINE_STATE, 8'h11);
    idle(2);
    final_report();
  end
endmodule : tb_top
